// ### hw/sdma_pkg.sv
package sdma_pkg;

  // ********************************************************
  // sizes
  // ********************************************************
  localparam int NUM_CH = 6;
  localparam int NUM_DEV = 16;
  localparam int BUF_BYTES = 16;

  // ********************************************************
  // register offsets inside one channel (stride 0x20)
  // ********************************************************
  localparam logic [4:0] OFF_DDAR = 5'h00;
  localparam logic [4:0] OFF_CSR = 5'h04;
  localparam logic [4:0] OFF_BSA = 5'h08;
  localparam logic [4:0] OFF_BTA = 5'h0C;
  localparam logic [4:0] OFF_BSB = 5'h10;
  localparam logic [4:0] OFF_BTB = 5'h14;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int DDAR_RW = 0;
  localparam int DDAR_E = 1;
  localparam int DDAR_BS = 2;
  localparam int DDAR_DW = 3;
  localparam int CSR_RUN = 0;
  localparam int CSR_STRA = 1;
  localparam int CSR_DNA = 2;
  localparam int CSR_STRB = 3;
  localparam int CSR_DNB = 4;
  localparam int CSR_ERR = 5;
  localparam int CSR_IBUF = 7;
  localparam logic [31:0] CSR_RST = 32'h0000_0080;

  // ********************************************************
  // forbidden card window
  // ********************************************************
  localparam logic [31:0] PCM_LO = 32'h2000_0000;
  localparam logic [31:0] PCM_HI = 32'h3FFF_FFFF;

  // ********************************************************
  // types
  // ********************************************************
  typedef enum {S_IDLE, S_MRD, S_PWR, S_PRD, S_MWR, S_TURN, S_END} sdma_st_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sdma_mem_t;

  typedef struct packed {
    logic req;
    logic we;
    logic wide;
    logic [31:0] addr;
    logic [15:0] wdata;
  } sdma_per_t;

endpackage

// ### hw/sdma_top.sv
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sdma_top #(
  parameter int NCH = sdma_pkg::NUM_CH,
  parameter int NDEV = sdma_pkg::NUM_DEV
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // device requests
  input wire logic [NDEV-1:0] dev_dreq,
  // memory port
  output sdma_pkg::sdma_mem_t mem_o,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // device port
  output sdma_pkg::sdma_per_t per_o,
  input wire logic per_ack,
  input wire logic [15:0] per_rdata
);
  import sdma_pkg::*;

  // ********************************************************
  // channel storage
  // ********************************************************
  logic [31:0] ddar_q [NCH];
  logic [31:0] bsa_q [NCH];
  logic [31:0] bsb_q [NCH];
  logic [31:0] bta_q [NCH];
  logic [31:0] btb_q [NCH];
  logic [NCH-1:0] run_q, sta_q, stb_q, dna_q, dnb_q, biu_q, err_q;
  logic [7:0] bb_q [BUF_BYTES];
  sdma_st_t st_q, st_d;
  logic [2:0] cur_q, cur_d, pick;
  logic [3:0] idx_q, idx_d;
  logic rd_pend_q;
  logic [31:0] rdata_q;

  function automatic logic in_pcm(input logic [31:0] a);
    return (a >= PCM_LO) && (a <= PCM_HI);
  endfunction

  function automatic logic [4:0] burst_bytes(input logic [31:0] c);
    return 5'h04 << ({1'b0, c[DDAR_BS]} + {1'b0, c[DDAR_DW]});
  endfunction

  // ********************************************************
  // bus decode
  // ********************************************************
  wire logic [2:0] a_ch = avs_address[7:5];
  wire logic [4:0] a_off = avs_address[4:0];
  wire logic a_ok = a_ch < 3'(NCH);
  wire logic wr_hit = avs_write && a_ok;
  wire logic wr_ddar = wr_hit && a_off == OFF_DDAR && !run_q[a_ch];
  wire logic wr_csr = wr_hit && a_off == OFF_CSR;
  wire logic [31:0] wd = avs_writedata;
  wire logic [31:0] csr_rd = {24'h00_0000, ~biu_q[a_ch], 1'b0, err_q[a_ch],
    dnb_q[a_ch], stb_q[a_ch], dna_q[a_ch], sta_q[a_ch], run_q[a_ch]};
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (a_ok) begin
      case (a_off)
        OFF_DDAR: rd_mux = ddar_q[a_ch];
        OFF_CSR: rd_mux = csr_rd;
        OFF_BSA: rd_mux = bsa_q[a_ch];
        OFF_BTA: rd_mux = bta_q[a_ch];
        OFF_BSB: rd_mux = bsb_q[a_ch];
        OFF_BTB: rd_mux = btb_q[a_ch];
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  assign avs_waitrequest = avs_read && !rd_pend_q;
  assign avs_readdata = rdata_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_pend_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      rd_pend_q <= avs_read && !rd_pend_q;
      if (avs_read) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // ********************************************************
  // arbitration
  // ********************************************************
  logic [NCH-1:0] elig;
  always_comb begin
    elig = '0;
    pick = 3'h0;
    for (int i = 0; i < NCH; i++) begin
      elig[i] = run_q[i] && (biu_q[i] ? stb_q[i] : sta_q[i]) && !err_q[i]
        && dev_dreq[ddar_q[i][7:4]];
    end
    for (int i = NCH - 1; i >= 0; i--) begin
      if (elig[i]) begin
        pick = 3'(i);
      end
    end
  end

  wire logic any_elig = |elig;
  wire logic [31:0] pbase = biu_q[pick] ? bsb_q[pick] : bsa_q[pick];
  wire logic [31:0] plast = pbase + 32'(burst_bytes(ddar_q[pick])) - 32'h1;
  wire logic pick_bad = in_pcm(pbase) || in_pcm(plast);
  wire logic idle = st_q == S_IDLE;
  wire logic abort = idle && any_elig && pick_bad;

  // ********************************************************
  // current channel view
  // ********************************************************
  wire logic [31:0] ccfg = ddar_q[cur_q];
  wire logic cbuf = biu_q[cur_q];
  wire logic [31:0] ccnt = cbuf ? btb_q[cur_q] : bta_q[cur_q];
  wire logic [4:0] cbytes = burst_bytes(ccfg);
  wire logic [3:0] cbeats = ccfg[DDAR_BS] ? 4'h8 : 4'h4;
  wire logic [3:0] cwords = 4'(cbytes >> 2);
  wire logic last_word = idx_q == cwords - 4'h1;
  wire logic last_beat = idx_q == cbeats - 4'h1;
  wire logic fin = st_q == S_END;
  wire logic cdone = ccnt <= 32'(cbytes);
  wire logic wide_q = ccfg[DDAR_DW];
  wire logic [4:0] kq = wide_q ? {idx_q, 1'b0} : {1'b0, idx_q};

  // ********************************************************
  // transfer engine
  // ********************************************************
  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    cur_d = cur_q;
    case (st_q)
      S_IDLE: begin
        if (any_elig && !pick_bad) begin
          cur_d = pick;
          idx_d = 4'h0;
          st_d = ddar_q[pick][DDAR_RW] ? S_PRD : S_MRD;
        end
      end
      S_MRD: begin
        if (mem_ack) begin
          idx_d = last_word ? 4'h0 : idx_q + 4'h1;
          st_d = last_word ? S_TURN : S_MRD;
        end
      end
      S_PRD: begin
        if (per_ack) begin
          idx_d = last_beat ? 4'h0 : idx_q + 4'h1;
          st_d = last_beat ? S_TURN : S_PRD;
        end
      end
      S_TURN: st_d = ccfg[DDAR_RW] ? S_MWR : S_PWR;
      S_PWR: begin
        if (per_ack) begin
          idx_d = last_beat ? 4'h0 : idx_q + 4'h1;
          st_d = last_beat ? S_END : S_PWR;
        end
      end
      S_MWR: begin
        if (mem_ack) begin
          idx_d = last_word ? 4'h0 : idx_q + 4'h1;
          st_d = last_word ? S_END : S_MWR;
        end
      end
      S_END: st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end

  // next outputs, registered below
  wire logic [31:0] dcfg = ddar_q[cur_d];
  wire logic [31:0] dbase = biu_q[cur_d] ? bsb_q[cur_d] : bsa_q[cur_d];
  wire logic dwide = dcfg[DDAR_DW];
  wire logic [4:0] kd = dwide ? {idx_d, 1'b0} : {1'b0, idx_d};
  sdma_mem_t mem_d;
  sdma_per_t per_d;

  always_comb begin
    mem_d.req = st_d == S_MRD || st_d == S_MWR;
    mem_d.we = st_d == S_MWR;
    mem_d.addr = dbase + {26'h000_0000, idx_d, 2'b00};
    for (int l = 0; l < 4; l++) begin
      mem_d.wdata[l*8 +: 8] =
        bb_q[{idx_d[1:0], dcfg[DDAR_E] ? ~2'(l) : 2'(l)}];
    end
    per_d.req = st_d == S_PWR || st_d == S_PRD;
    per_d.we = st_d == S_PWR;
    per_d.wide = dwide;
    per_d.addr = {dcfg[31:28], 6'h00, dcfg[27:8], 2'b00};
    per_d.wdata = {dwide ? bb_q[4'(kd + 5'h1)] : 8'h00, bb_q[kd[3:0]]};
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= S_IDLE;
      cur_q <= 3'h0;
      idx_q <= 4'h0;
      mem_o <= '0;
      per_o <= '0;
    end else begin
      st_q <= st_d;
      cur_q <= cur_d;
      idx_q <= idx_d;
      mem_o <= mem_d;
      per_o <= per_d;
    end
  end

  // burst buffer, byte lanes set by the endian bit
  always_ff @(posedge sys_clk) begin
    if (st_q == S_MRD && mem_ack) begin
      for (int l = 0; l < 4; l++) begin
        bb_q[{idx_q[1:0], ccfg[DDAR_E] ? ~2'(l) : 2'(l)}] <=
          mem_rdata[l*8 +: 8];
      end
    end
    if (st_q == S_PRD && per_ack) begin
      bb_q[kq[3:0]] <= per_rdata[7:0];
      if (wide_q) begin
        bb_q[4'(kq + 5'h1)] <= per_rdata[15:8];
      end
    end
  end

  // ********************************************************
  // channel registers
  // ********************************************************
  // configuration words keep no reset value
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (wr_ddar && a_ch == 3'(i)) ddar_q[i] <= wd;
      if (wr_hit && a_ch == 3'(i) && a_off == OFF_BSA) bsa_q[i] <= wd;
      if (wr_hit && a_ch == 3'(i) && a_off == OFF_BTA) bta_q[i] <= wd;
      if (wr_hit && a_ch == 3'(i) && a_off == OFF_BSB) bsb_q[i] <= wd;
      if (wr_hit && a_ch == 3'(i) && a_off == OFF_BTB) btb_q[i] <= wd;
      if (fin && cur_q == 3'(i) && !cbuf) begin
        bsa_q[i] <= bsa_q[i] + 32'(cbytes);
        bta_q[i] <= bta_q[i] - 32'(cbytes);
      end
      if (fin && cur_q == 3'(i) && cbuf) begin
        bsb_q[i] <= bsb_q[i] + 32'(cbytes);
        btb_q[i] <= btb_q[i] - 32'(cbytes);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {run_q, sta_q, stb_q, dna_q, dnb_q, biu_q, err_q} <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (fin && cur_q == 3'(i) && cdone) begin
          biu_q[i] <= ~cbuf;
          if (cbuf) stb_q[i] <= 1'b0;
          else sta_q[i] <= 1'b0;
        end
        if (wr_csr && a_ch == 3'(i)) begin
          run_q[i] <= wd[CSR_RUN];
          if (wd[CSR_STRA]) sta_q[i] <= 1'b1;
          if (wd[CSR_STRB]) stb_q[i] <= 1'b1;
          if (wd[CSR_DNA]) dna_q[i] <= 1'b0;
          if (wd[CSR_DNB]) dnb_q[i] <= 1'b0;
          if (wd[CSR_ERR]) err_q[i] <= 1'b0;
        end
        if (fin && cur_q == 3'(i) && cdone && !cbuf) dna_q[i] <= 1'b1;
        if (fin && cur_q == 3'(i) && cdone && cbuf) dnb_q[i] <= 1'b1;
        if (abort && pick == 3'(i)) begin
          err_q[i] <= 1'b1;
          run_q[i] <= 1'b0;
        end
      end
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  logic [3:0] beat_q;
  logic lk_q;
  logic [2:0] lk_ch_q;
  logic [31:0] lk_val_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      beat_q <= 4'h0;
      lk_q <= 1'b0;
      lk_ch_q <= 3'h0;
      lk_val_q <= 32'h0000_0000;
    end else begin
      beat_q <= idle ? 4'h0 : beat_q + 4'(per_ack && per_o.req);
      lk_q <= wr_hit && a_off == OFF_DDAR && run_q[a_ch];
      lk_ch_q <= a_ch;
      lk_val_q <= ddar_q[a_ch];
    end
  end

  prio_order_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (idle && any_elig) |-> (elig & NCH'((1 << pick) - 1)) == '0)
    else $error("lower channel passed over");
  burst_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!idle && $past(st_q) != S_IDLE) |-> $stable(cur_q))
    else $error("channel switched inside a burst");
  ddar_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    lk_q |-> ddar_q[lk_ch_q] == lk_val_q)
    else $error("device address changed while running");
  idle_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (idle && run_q == '0) |=> idle && !mem_o.req && !per_o.req)
    else $error("access with no channel running");
  pcm_guard_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    mem_o.req |-> !in_pcm(mem_o.addr))
    else $error("access into card window");
  dir_match_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    per_o.req |-> per_o.we == !ccfg[DDAR_RW] && mem_o.req == 1'b0)
    else $error("device direction wrong");
  width_match_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    per_o.req |-> per_o.wide == ccfg[DDAR_DW])
    else $error("datum width wrong");
  beat_count_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fin |-> beat_q == cbeats)
    else $error("burst beat count wrong");
  buf_chain_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (fin && cdone) |=> biu_q != $past(biu_q) ##0 idle)
    else $error("buffer did not switch");
  mem_dir_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (mem_o.req && mem_o.we) |-> ccfg[DDAR_RW])
    else $error("memory write on outgoing channel");

endmodule
`default_nettype wire

// ### testbench/sdma_partner.sv
`timescale 1ns/1ps
`default_nettype none
module sdma_partner (
  // clock, reset, pace
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic slow,
  // memory side
  input wire sdma_pkg::sdma_mem_t mem_o,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // device side
  input wire sdma_pkg::sdma_per_t per_o,
  output logic per_ack,
  output logic [15:0] per_rdata
);
  import sdma_pkg::*;
  logic [31:0] mem [logic [31:0]];
  int mwait;
  int pwait;
  logic [7:0] seq;

  // ********
  // slaves ack after two or four waits; idle data lines toggle
  // ********
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      per_ack <= 1'b0;
      per_rdata <= 16'h0000;
      mwait = 0;
      pwait = 0;
      seq = 8'h00;
    end else begin
      mem_ack <= 1'b0;
      per_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      per_rdata <= ~per_rdata;
      if (mem_o.req && !mem_ack) mwait = mwait + 1;
      if (mwait > (slow ? 3 : 1)) begin
        mwait = 0;
        mem_ack <= 1'b1;
        if (mem_o.we) mem[mem_o.addr] = mem_o.wdata;
        else mem_rdata <= {~mem_o.addr[15:0], mem_o.addr[15:0]};
      end
      if (per_o.req && !per_ack) pwait = pwait + 1;
      if (pwait > (slow ? 3 : 1)) begin
        pwait = 0;
        per_ack <= 1'b1;
        if (!per_o.we) begin
          per_rdata <= {seq ^ 8'hA5, seq};
          seq = seq + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sdma_pkg::*;
  logic sys_clk;
  logic rst_b;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [NUM_DEV-1:0] dev_dreq;
  sdma_mem_t mem_o;
  logic mem_ack;
  logic [31:0] mem_rdata;
  sdma_per_t per_o;
  logic per_ack;
  logic [15:0] per_rdata;
  logic slow;
  int seed = 58;
  int fail_count = 0;
  int checks = 0;
  logic [64:0] mlog[$];
  logic [17:0] plog[$];
  logic [31:0] rd;
  logic [31:0] d;
  logic e;
  logic [4:0] offs [5] = '{OFF_DDAR, OFF_BSA, OFF_BTA, OFF_BSB, OFF_BTB};

  sdma_top dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dev_dreq(dev_dreq),
    .mem_o(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .per_o(per_o), .per_ack(per_ack), .per_rdata(per_rdata));
  sdma_partner partner (.sys_clk(sys_clk), .rst_b(rst_b), .slow(slow),
    .mem_o(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .per_o(per_o), .per_ack(per_ack), .per_rdata(per_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ********
  // log every completed access in order
  // ********
  always @(posedge sys_clk) begin
    slow <= 1'($random(seed));
    if (mem_ack)
      mlog.push_back({mem_o.we, mem_o.addr, mem_o.we ? mem_o.wdata : mem_rdata});
    if (per_ack) begin
      plog.push_back({per_o.we, per_o.wide, per_o.we ? per_o.wdata : per_rdata});
      cmp("port address", 32'h8000_0028, per_o.addr);
    end
  end

  // ********
  // helpers
  // ********
  task automatic cmp(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [7:0] ra(input int ch, input logic [4:0] off);
    return {ch[2:0], off};
  endfunction

  function automatic logic [31:0] dd(input logic [3:0] ds,
      input logic dir, input logic en, input logic bs, input logic dw);
    return {24'h80_000A, ds, dw, bs, en, dir};
  endfunction

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    v = avs_readdata;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic prog(input int ch, input logic [31:0] ddar,
      input logic [31:0] base, input int cnt, input logic [31:0] csr);
    bus_wr(ra(ch, OFF_DDAR), ddar);
    bus_wr(ra(ch, OFF_BSA), base);
    bus_wr(ra(ch, OFF_BTA), cnt);
    bus_wr(ra(ch, OFF_BSB), base + cnt);
    bus_wr(ra(ch, OFF_BTB), cnt);
    bus_wr(ra(ch, OFF_CSR), csr);
  endtask

  task automatic wait_done(input int ch, input logic [31:0] mask,
      input logic [31:0] keep, input logic [31:0] exp);
    int n;
    n = 0;
    rd = 32'h0000_0000;
    while ((rd & mask) !== mask && n < 300) begin
      bus_rd(ra(ch, OFF_CSR), rd);
      n++;
    end
    cmp("status", exp, rd & keep);
  endtask

  task automatic check_seg(input logic dir, input logic en, input logic dw,
      input logic [31:0] base, input int cnt);
    logic [64:0] m[$];
    logic [17:0] p[$];
    logic [7:0] s[$];
    logic [31:0] w;
    int n;
    n = dw ? cnt / 2 : cnt;
    cmp("log size", 1, mlog.size() >= cnt / 4 && plog.size() >= n);
    if (mlog.size() < cnt / 4 || plog.size() < n) return;
    repeat (cnt / 4) m.push_back(mlog.pop_front());
    repeat (n) p.push_back(plog.pop_front());
    foreach (m[i]) begin
      cmp("mem address", base + 4 * i, m[i][63:32]);
      cmp("mem write", dir, m[i][64]);
      if (!dir)
        for (int k = 0; k < 4; k++) s.push_back(m[i][8 * (en ? 3 - k : k) +: 8]);
    end
    foreach (p[j]) begin
      cmp("port write", !dir, p[j][17]);
      cmp("port wide", dw, p[j][16]);
      if (dir) begin
        s.push_back(p[j][7:0]);
        if (dw) s.push_back(p[j][15:8]);
      end else
        cmp("port data", dw ? {s[2*j+1], s[2*j]} : s[j], dw ? p[j][15:0] : p[j][7:0]);
    end
    if (dir) foreach (m[i]) begin
      for (int k = 0; k < 4; k++) w[8 * (en ? 3 - k : k) +: 8] = s[4 * i + k];
      cmp("mem data", w, m[i][31:0]);
    end
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    $display("BAD watchdog expected finish seen hang");
    stop_test();
  end

  // ********
  // main sequence
  // ********
  initial begin
    rst_b = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    dev_dreq = 16'h0000;
    repeat (6) @(posedge sys_clk) dev_dreq <= 16'($random(seed));
    rst_b <= 1'b1;
    repeat (10) begin
      @(posedge sys_clk);
      dev_dreq <= 16'($random(seed));
      @(negedge sys_clk);
      cmp("idle requests", 0, {mem_o.req, per_o.req});
    end
    @(posedge sys_clk);
    dev_dreq <= 16'h0000;
    for (int c = 0; c < NUM_CH; c++) begin
      bus_rd(ra(c, OFF_CSR), rd);
      cmp("csr reset", CSR_RST, rd);
    end
    bus_rd(8'hC0, rd);
    cmp("unmapped channel", 0, rd);
    bus_rd(ra(0, 5'h1C), rd);
    cmp("unmapped offset", 0, rd);
    foreach (offs[i]) begin
      d = $random(seed);
      bus_wr(ra(0, offs[i]), d);
      bus_rd(ra(0, offs[i]), rd);
      cmp("register", d, rd);
    end
    e = 1'($random(seed));
    d = dd(4, 0, e, 0, 0);
    prog(1, d, 32'h0000_1000, 8, 32'h0000_0003);
    bus_wr(ra(1, OFF_DDAR), 32'h0000_00F0);
    bus_rd(ra(1, OFF_DDAR), rd);
    cmp("locked ddar", d, rd);
    dev_dreq <= 16'h0010;
    wait_done(1, 32'h0000_0004, 32'h0000_00BF, 32'h0000_0005);
    dev_dreq <= 16'h0000;
    check_seg(0, e, 0, 32'h0000_1000, 8);
    prog(0, dd(5, 1, e, 1, 1), 32'h0000_2000, 32, 32'h0000_0003);
    dev_dreq <= 16'h0020;
    wait_done(0, 32'h0000_0004, 32'h0000_00BF, 32'h0000_0005);
    dev_dreq <= 16'h0000;
    check_seg(1, e, 1, 32'h0000_2000, 32);
    prog(4, dd(12, 0, e, 0, 0), 32'h0000_4000, 8, 32'h0000_0003);
    prog(2, dd(12, 1, e, 0, 0), 32'h0000_3000, 8, 32'h0000_0003);
    dev_dreq <= 16'h1000;
    wait_done(4, 32'h0000_0004, 32'h0000_00BF, 32'h0000_0005);
    dev_dreq <= 16'h0000;
    check_seg(1, e, 0, 32'h0000_3000, 8);
    check_seg(0, e, 0, 32'h0000_4000, 8);
    prog(3, dd(14, 0, e, 1, 0), 32'h0000_5000, 8, 32'h0000_000B);
    dev_dreq <= 16'h4000;
    wait_done(3, 32'h0000_0014, 32'h0000_00BF, 32'h0000_0095);
    dev_dreq <= 16'h0000;
    check_seg(0, e, 0, 32'h0000_5000, 8);
    check_seg(0, e, 0, 32'h0000_5008, 8);
    prog(5, dd(15, 0, e, 0, 0), 32'h2000_0040, 8, 32'h0000_0003);
    dev_dreq <= 16'h8000;
    wait_done(5, 32'h0000_0020, 32'h0000_0021, 32'h0000_0020);
    repeat (20) @(posedge sys_clk);
    cmp("card window accesses", 0, mlog.size() + plog.size());
    stop_test();
  end
endmodule
`default_nettype wire
